/* File: core/sfrm_pkg.sv */
// Purpose: constants shared by the read-mode parameter table block
// Assumes: classic wishbone slave, 32-bit data, one register per aligned word
// Notes: register byte address is four times the register index

package sfrm_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] SFRM_OFF_FIRST = 6'h08;
  localparam logic [5:0] SFRM_OFF_QUAD_IO_WAIT = 6'h08;
  localparam logic [5:0] SFRM_OFF_QUAD_IO_OPCODE = 6'h09;
  localparam logic [5:0] SFRM_OFF_QUAD_OUT_WAIT = 6'h0a;
  localparam logic [5:0] SFRM_OFF_QUAD_OUT_OPCODE = 6'h0b;
  localparam logic [5:0] SFRM_OFF_DUAL_OUT_WAIT = 6'h0c;
  localparam logic [5:0] SFRM_OFF_DUAL_OUT_OPCODE = 6'h0d;
  localparam logic [5:0] SFRM_OFF_DUAL_IO_WAIT = 6'h0e;
  localparam logic [5:0] SFRM_OFF_DUAL_IO_OPCODE = 6'h0f;
  localparam logic [5:0] SFRM_OFF_WIDE_FLAGS = 6'h10;
  localparam logic [5:0] SFRM_OFF_RSVD_LO_FIRST = 6'h11;
  localparam logic [5:0] SFRM_OFF_RSVD_LO_LAST = 6'h15;
  localparam logic [5:0] SFRM_OFF_DUAL_ALL_WAIT = 6'h16;
  localparam logic [5:0] SFRM_OFF_DUAL_ALL_OPCODE = 6'h17;
  localparam logic [5:0] SFRM_OFF_RSVD_HI_FIRST = 6'h18;
  localparam logic [5:0] SFRM_OFF_RSVD_HI_LAST = 6'h19;
  localparam logic [5:0] SFRM_OFF_FOUR_WIRE_WAIT = 6'h1a;
  localparam logic [5:0] SFRM_OFF_FOUR_WIRE_OPCODE = 6'h1b;
  localparam logic [5:0] SFRM_OFF_LAST = 6'h1b;
  localparam logic [5:0] SFRM_IDX_PROBE_ADDR = 6'h20;
  localparam logic [5:0] SFRM_IDX_PROBE_DATA = 6'h21;
  localparam logic [5:0] SFRM_IDX_STATUS = 6'h22;
  localparam logic [5:0] SFRM_IDX_BASE = 6'h23;
  localparam logic [5:0] SFRM_IDX_CTRL = 6'h24;

  // ----------------------------------------------------------------
  // table contents and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] SFRM_TABLE_BASE = 16'h1090;
  localparam logic [7:0] SFRM_VAL_QUAD_IO_WAIT = 8'h48;
  localparam logic [7:0] SFRM_VAL_QUAD_IO_OPCODE = 8'heb;
  localparam logic [7:0] SFRM_VAL_NOT_OFFERED = 8'hff;
  localparam logic [7:0] SFRM_VAL_DUAL_IO_WAIT = 8'h88;
  localparam logic [7:0] SFRM_VAL_DUAL_IO_OPCODE = 8'hbb;
  localparam logic [7:0] SFRM_VAL_WIDE_FLAGS = 8'hfe;
  localparam logic [7:0] SFRM_VAL_RESERVED = 8'hff;
  localparam logic [7:0] SFRM_VAL_FOUR_WIRE_WAIT = 8'h48;
  localparam logic [7:0] SFRM_VAL_FOUR_WIRE_OPCODE = 8'heb;
  localparam logic [7:0] SFRM_VAL_ABSENT = 8'hff;
  localparam int SFRM_BIT_FOUR_WIRE = 4;
  localparam int SFRM_BIT_DUAL_ALL = 0;
  localparam int SFRM_ROM_DEPTH = 20;
  localparam logic [7:0] SFRM_ROM [0:SFRM_ROM_DEPTH-1] = '{
    SFRM_VAL_QUAD_IO_WAIT, SFRM_VAL_QUAD_IO_OPCODE, SFRM_VAL_NOT_OFFERED, SFRM_VAL_NOT_OFFERED,
    SFRM_VAL_NOT_OFFERED, SFRM_VAL_NOT_OFFERED, SFRM_VAL_DUAL_IO_WAIT, SFRM_VAL_DUAL_IO_OPCODE,
    SFRM_VAL_WIDE_FLAGS, SFRM_VAL_RESERVED, SFRM_VAL_RESERVED, SFRM_VAL_RESERVED,
    SFRM_VAL_RESERVED, SFRM_VAL_RESERVED, SFRM_VAL_NOT_OFFERED, SFRM_VAL_NOT_OFFERED,
    SFRM_VAL_RESERVED, SFRM_VAL_RESERVED, SFRM_VAL_FOUR_WIRE_WAIT, SFRM_VAL_FOUR_WIRE_OPCODE
  };

  // ----------------------------------------------------------------
  // own control and status layout
  // ----------------------------------------------------------------
  localparam int SFRM_BIT_WR_SEEN = 0;
  localparam int SFRM_BIT_PROBE_MISS = 1;
  localparam int SFRM_BIT_CNT_CLR = 8;
  localparam int SFRM_BIT_AUTOINC = 0;
  localparam logic SFRM_RST_AUTOINC = 1'b1;
  localparam logic [15:0] SFRM_RST_PROBE_ADDR = 16'h1090;
  localparam int SFRM_CNT_W = 8;

endpackage : sfrm_pkg

/* File: core/sfrm_wb_ack.sv */
// Purpose: classic wishbone single-cycle acknowledge
// Assumes: master holds cyc and stb until it samples ack
// Notes: ack stands one cycle; take marks the edge where the request is served
`timescale 1ns/1ps

module sfrm_wb_ack (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic take_o,
  output logic ack_o
);

  // no back-to-back ack: a request held past its ack is served again on every second edge
  assign take_o = cyc_i & stb_i & ~ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= take_o;
    end
  end

endmodule : sfrm_wb_ack

/* File: core/sfrm_sat_cnt.sv */
// Purpose: saturating event counter
// Assumes: inc and clr come from logic on the same clock
// Notes: an increment in the clearing cycle is kept
`timescale 1ns/1ps

module sfrm_sat_cnt (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic inc_i,
  input wire logic clr_i,
  output logic [sfrm_pkg::SFRM_CNT_W-1:0] cnt_o
);
  import sfrm_pkg::*;

  localparam logic [SFRM_CNT_W-1:0] CNT_MAX = '1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o <= '0;
    end else if (clr_i) begin
      cnt_o <= inc_i ? SFRM_CNT_W'(1) : '0;
    end else if (inc_i && cnt_o != CNT_MAX) begin
      cnt_o <= cnt_o + SFRM_CNT_W'(1);
    end
  end

endmodule : sfrm_sat_cnt

/* File: core/sfrm_param_rom.sv */
// Purpose: read-mode parameter table with a wishbone register view
// Assumes: classic wishbone, byte address on adr_i, register index in adr_i[7:2]
// Notes: table bytes also reachable by absolute address through the probe port
`timescale 1ns/1ps

module sfrm_param_rom (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  import sfrm_pkg::*;

  // ----------------------------------------------------------------
  // table lookup
  // ----------------------------------------------------------------
  function automatic logic [8:0] rom_lookup(input logic [5:0] off);
    logic [5:0] rel;
    rel = 6'(off - SFRM_OFF_FIRST);
    if (off >= SFRM_OFF_FIRST && off <= SFRM_OFF_LAST) begin
      return {1'b1, SFRM_ROM[rel[4:0]]};
    end
    return {1'b0, SFRM_VAL_ABSENT};
  endfunction : rom_lookup

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic take;
  logic [5:0] idx;
  logic rd_take;
  logic wr_take;

  sfrm_wb_ack u_ack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .take_o(take),
    .ack_o(ack_o)
  );

  assign idx = adr_i[7:2];
  assign rd_take = take & ~we_i;
  assign wr_take = take & we_i;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] probe_addr_r;
  logic autoinc_r;
  logic wr_seen_r;
  logic [SFRM_CNT_W-1:0] wr_cnt;
  logic [8:0] bus_look;
  logic [15:0] probe_rel;
  logic [8:0] probe_look;
  logic probe_hit;
  logic rom_wr;
  logic seen_clr;
  logic cnt_clr;
  logic [31:0] rd_data;

  assign bus_look = rom_lookup(idx);
  // base subtraction maps absolute addresses onto table offsets
  assign probe_rel = probe_addr_r - SFRM_TABLE_BASE;
  assign probe_look = rom_lookup(probe_rel[5:0]);
  assign probe_hit = (probe_rel[15:6] == 10'h000) & probe_look[8];

  // a write aimed at a table byte stores nothing, it is only counted and flagged in wr_seen_r
  assign rom_wr = wr_take & bus_look[8];
  assign seen_clr = wr_take & (idx == SFRM_IDX_STATUS) & sel_i[0] & dat_i[SFRM_BIT_WR_SEEN];
  assign cnt_clr = wr_take & (idx == SFRM_IDX_STATUS) & sel_i[1] & dat_i[SFRM_BIT_CNT_CLR];

  sfrm_sat_cnt u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(rom_wr),
    .clr_i(cnt_clr),
    .cnt_o(wr_cnt)
  );

  // ----------------------------------------------------------------
  // probe address, auto-increment on each data read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      probe_addr_r <= SFRM_RST_PROBE_ADDR;
    end else if (wr_take && idx == SFRM_IDX_PROBE_ADDR) begin
      if (sel_i[0]) begin
        probe_addr_r[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        probe_addr_r[15:8] <= dat_i[15:8];
      end
    end else if (rd_take && idx == SFRM_IDX_PROBE_DATA && autoinc_r) begin
      probe_addr_r <= probe_addr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      autoinc_r <= SFRM_RST_AUTOINC;
    end else if (wr_take && idx == SFRM_IDX_CTRL && sel_i[0]) begin
      autoinc_r <= dat_i[SFRM_BIT_AUTOINC];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= rom_wr | (wr_seen_r & ~seen_clr);
    end
  end

  // ----------------------------------------------------------------
  // read mux, unmapped words read zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    if (bus_look[8]) begin
      rd_data[7:0] = bus_look[7:0];
    end else begin
      unique case (idx)
        SFRM_IDX_PROBE_ADDR: rd_data[15:0] = probe_addr_r;
        SFRM_IDX_PROBE_DATA: rd_data[7:0] = probe_look[7:0];
        SFRM_IDX_STATUS: begin
          rd_data[SFRM_BIT_WR_SEEN] = wr_seen_r;
          rd_data[SFRM_BIT_PROBE_MISS] = ~probe_hit;
          rd_data[SFRM_BIT_CNT_CLR +: SFRM_CNT_W] = wr_cnt;
        end
        SFRM_IDX_BASE: rd_data[15:0] = SFRM_TABLE_BASE;
        SFRM_IDX_CTRL: rd_data[SFRM_BIT_AUTOINC] = autoinc_r;
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // probe misses read the erased value unless probe_rel[5:0] aliases a table offset, never stale data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_take) begin
      dat_o <= rd_data;
    end else if (wr_take) begin
      dat_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [5:0] chk_idx_r;
  logic chk_rd_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_idx_r <= 6'h00;
      chk_rd_r <= 1'b0;
    end else if (take) begin
      chk_idx_r <= idx;
      chk_rd_r <= ~we_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_quad_io_wait;
    ack_o && chk_rd_r && chk_idx_r == SFRM_OFF_QUAD_IO_WAIT |-> dat_o == {24'h00_0000, SFRM_VAL_QUAD_IO_WAIT};
  endproperty
  a_quad_io_wait: assert property (p_quad_io_wait) else $error("quad io wait byte wrong");

  property p_quad_io_opcode;
    rd_take && idx == SFRM_OFF_QUAD_IO_OPCODE |=> ack_o && dat_o[7:0] == SFRM_VAL_QUAD_IO_OPCODE;
  endproperty
  a_quad_io_opcode: assert property (p_quad_io_opcode) else $error("quad io opcode wrong");

  property p_quad_out_absent;
    ack_o && chk_rd_r && (chk_idx_r == SFRM_OFF_QUAD_OUT_WAIT || chk_idx_r == SFRM_OFF_QUAD_OUT_OPCODE)
      |-> dat_o[7:0] == SFRM_VAL_NOT_OFFERED;
  endproperty
  a_quad_out_absent: assert property (p_quad_out_absent) else $error("quad out not all ones");

  property p_dual_out_absent;
    ack_o && chk_rd_r && (chk_idx_r == SFRM_OFF_DUAL_OUT_WAIT || chk_idx_r == SFRM_OFF_DUAL_OUT_OPCODE)
      |-> dat_o[7:0] == SFRM_VAL_NOT_OFFERED;
  endproperty
  a_dual_out_absent: assert property (p_dual_out_absent) else $error("dual out not all ones");

  property p_dual_io_pair;
    rd_take && idx == SFRM_OFF_DUAL_IO_WAIT ##1 ack_o
      |-> dat_o[7:0] == SFRM_VAL_DUAL_IO_WAIT && $past(bus_look[7:0]) == SFRM_VAL_DUAL_IO_WAIT;
  endproperty
  a_dual_io_pair: assert property (p_dual_io_pair) else $error("dual io wait byte wrong");

  property p_dual_io_opcode;
    ack_o && chk_rd_r && chk_idx_r == SFRM_OFF_DUAL_IO_OPCODE |-> dat_o == {24'h00_0000, SFRM_VAL_DUAL_IO_OPCODE};
  endproperty
  a_dual_io_opcode: assert property (p_dual_io_opcode) else $error("dual io opcode wrong");

  property p_wide_flags;
    ack_o && chk_rd_r && chk_idx_r == SFRM_OFF_WIDE_FLAGS
      |-> dat_o[7:0] == SFRM_VAL_WIDE_FLAGS && dat_o[SFRM_BIT_FOUR_WIRE];
  endproperty
  a_wide_flags: assert property (p_wide_flags) else $error("wide mode flags wrong");

  property p_dual_all_flag;
    ack_o && chk_rd_r && chk_idx_r == SFRM_OFF_WIDE_FLAGS |-> !dat_o[SFRM_BIT_DUAL_ALL];
  endproperty
  a_dual_all_flag: assert property (p_dual_all_flag) else $error("dual all flag set");

  property p_reserved;
    ack_o && chk_rd_r && ((chk_idx_r >= SFRM_OFF_RSVD_LO_FIRST && chk_idx_r <= SFRM_OFF_RSVD_LO_LAST) ||
      (chk_idx_r >= SFRM_OFF_RSVD_HI_FIRST && chk_idx_r <= SFRM_OFF_RSVD_HI_LAST))
      |-> dat_o == {24'h00_0000, SFRM_VAL_RESERVED};
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte not all ones");

  property p_dual_all_absent;
    ack_o && chk_rd_r && (chk_idx_r == SFRM_OFF_DUAL_ALL_WAIT || chk_idx_r == SFRM_OFF_DUAL_ALL_OPCODE)
      |-> dat_o[7:0] == SFRM_VAL_NOT_OFFERED;
  endproperty
  a_dual_all_absent: assert property (p_dual_all_absent) else $error("dual all entry advertised");

  property p_four_wire_wait;
    ack_o && chk_rd_r && chk_idx_r == SFRM_OFF_FOUR_WIRE_WAIT |-> dat_o[7:0] == SFRM_VAL_FOUR_WIRE_WAIT;
  endproperty
  a_four_wire_wait: assert property (p_four_wire_wait) else $error("four wire wait byte wrong");

  property p_four_wire_opcode;
    rd_take && idx == SFRM_OFF_FOUR_WIRE_OPCODE |=> dat_o[7:0] == SFRM_VAL_FOUR_WIRE_OPCODE;
  endproperty
  a_four_wire_opcode: assert property (p_four_wire_opcode) else $error("four wire opcode wrong");

  property p_probe_base;
    rd_take && idx == SFRM_IDX_PROBE_DATA && probe_addr_r == SFRM_TABLE_BASE + 16'(SFRM_OFF_QUAD_IO_OPCODE)
      |=> dat_o[7:0] == SFRM_VAL_QUAD_IO_OPCODE;
  endproperty
  a_probe_base: assert property (p_probe_base) else $error("absolute address not mapped");

  property p_rom_write_ignored;
    rom_wr |=> wr_seen_r && dat_o == 32'h0000_0000 ##1 $stable(wr_seen_r);
  endproperty
  a_rom_write_ignored: assert property (p_rom_write_ignored) else $error("table write not absorbed");

  property p_rom_write_counted;
    rom_wr && !cnt_clr && wr_cnt != '1 |=> wr_cnt == $past(wr_cnt) + SFRM_CNT_W'(1);
  endproperty
  a_rom_write_counted: assert property (p_rom_write_counted) else $error("table write not counted");

  property p_ack_single;
    take |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack not a single cycle");

  property p_autoinc;
    rd_take && idx == SFRM_IDX_PROBE_DATA && autoinc_r |=> probe_addr_r == $past(probe_addr_r) + 16'h0001;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("probe address did not advance");

  // ----------------------------------------------------------------
  // register view checks
  // ----------------------------------------------------------------
  property p_wr_answer;
    wr_take |=> ack_o && dat_o == 32'h0000_0000;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer not zero");

  property p_table_upper_zero;
    ack_o && chk_rd_r && chk_idx_r >= SFRM_OFF_FIRST && chk_idx_r <= SFRM_OFF_LAST |-> dat_o[31:8] == 24'h00_0000;
  endproperty
  a_table_upper_zero: assert property (p_table_upper_zero) else $error("table word upper bits set");

  property p_base_read;
    ack_o && chk_rd_r && chk_idx_r == SFRM_IDX_BASE |-> dat_o == {16'h0000, SFRM_TABLE_BASE};
  endproperty
  a_base_read: assert property (p_base_read) else $error("base register wrong");

  property p_probe_hold;
    rd_take && idx == SFRM_IDX_PROBE_DATA && !autoinc_r |=> $stable(probe_addr_r);
  endproperty
  a_probe_hold: assert property (p_probe_hold) else $error("probe address moved without auto-increment");

  property p_probe_load;
    wr_take && idx == SFRM_IDX_PROBE_ADDR && sel_i[1:0] == 2'b11 |=> probe_addr_r == $past(dat_i[15:0]);
  endproperty
  a_probe_load: assert property (p_probe_load) else $error("probe address not loaded");

  property p_probe_lane0;
    wr_take && idx == SFRM_IDX_PROBE_ADDR && sel_i[1:0] == 2'b01
      |=> probe_addr_r == {$past(probe_addr_r[15:8]), $past(dat_i[7:0])};
  endproperty
  a_probe_lane0: assert property (p_probe_lane0) else $error("probe low lane write wrong");

  property p_ctrl_load;
    wr_take && idx == SFRM_IDX_CTRL && sel_i[0] |=> autoinc_r == $past(dat_i[SFRM_BIT_AUTOINC]);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control bit not loaded");

  property p_seen_clear;
    seen_clr && !rom_wr |=> !wr_seen_r;
  endproperty
  a_seen_clear: assert property (p_seen_clear) else $error("write seen flag not cleared");

  property p_cnt_clear;
    cnt_clr && !rom_wr |=> wr_cnt == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("write counter not cleared");

  property p_cnt_saturate;
    rom_wr && wr_cnt == '1 |=> wr_cnt == '1;
  endproperty
  a_cnt_saturate: assert property (p_cnt_saturate) else $error("write counter wrapped");

  property p_cnt_hold;
    !rom_wr && !cnt_clr |=> $stable(wr_cnt);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("write counter moved on its own");

  property p_ack_from_take;
    ack_o |-> $past(take);
  endproperty
  a_ack_from_take: assert property (p_ack_from_take) else $error("ack without a served request");

  property p_unmapped_zero;
    ack_o && chk_rd_r && (chk_idx_r < SFRM_OFF_FIRST || chk_idx_r > SFRM_IDX_CTRL ||
      (chk_idx_r > SFRM_OFF_LAST && chk_idx_r < SFRM_IDX_PROBE_ADDR)) |-> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped word not zero");

  property p_status_read;
    ack_o && chk_rd_r && chk_idx_r == SFRM_IDX_STATUS |-> dat_o[31:16] == 16'h0000 && dat_o[7:2] == 6'h00;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status spare bits set");

  property p_probe_miss_ff;
    rd_take && idx == SFRM_IDX_PROBE_DATA && !probe_hit |=> dat_o == {24'h00_0000, SFRM_VAL_ABSENT};
  endproperty
  a_probe_miss_ff: assert property (p_probe_miss_ff) else $error("probe miss not erased value");

  c_rom_read: cover property (rd_take && bus_look[8] ##1 ack_o);
  c_rom_write: cover property (rom_wr ##2 wr_seen_r);
  c_probe_hit: cover property (rd_take && idx == SFRM_IDX_PROBE_DATA && probe_hit);
  c_probe_miss: cover property (rd_take && idx == SFRM_IDX_PROBE_DATA && !probe_hit);

endmodule : sfrm_param_rom

/* File: test/sfrm_host_model.sv */
// Purpose: host-side wishbone master standing in for the controller that reads the table
// Assumes: classic single cycle, slave answers with a one-cycle ack
// Notes: waits for ack with no fixed count; only the bench watchdog ends a hang
`timescale 1ns/1ps

module sfrm_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // one bus cycle
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
                      output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= wd;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released lines flip so a stale value is never mistaken for a held one
    adr_o <= ~a;
    sel_o <= ~s;
    dat_o <= ~wd;
  endtask : xfer
endmodule : sfrm_host_model

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the read-mode parameter table
// Assumes: 250 MHz clock, synchronous reset held for 20 cycles
// Notes: expected table is written out here, not taken from the package array
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  int miscompares;
  int n_checks;
  localparam logic [7:0] EXP [0:19] = '{8'h48, 8'heb, 8'hff, 8'hff, 8'hff, 8'hff, 8'h88, 8'hbb, 8'hfe, 8'hff,
                                       8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h48, 8'heb};

  sfrm_param_rom dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
                      .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
  sfrm_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
                        .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // bus helpers and verdict
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0000_0000, 4'h0, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] dummy;
    host.xfer(1'b1, a, d, s, dummy);
  endtask : wr

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // whole run is about 1150 cycles; leave wide margin
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] d2;
    miscompares = 0;
    n_checks = 0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // every table byte at its index
    for (int i = 0; i < 20; i++) begin
      rd(8'((8 + i) * 4), d);
      `CHK("table", {24'h00_0000, EXP[i]}, d)
    end
    rd(8'h40, d);
    `CHK("four_wire_bit", 1'b1, d[4])
    `CHK("dual_all_bit", 1'b0, d[0])
    // writes to the table are ignored, but counted
    for (int i = 0; i < 20; i++) begin
      wr(8'((8 + i) * 4), 32'h0000_0000, 4'hf);
      rd(8'((8 + i) * 4), d);
      `CHK("table_after_wr", {24'h00_0000, EXP[i]}, d)
    end
    rd(8'h88, d);
    `CHK("status_after_wr", 32'h0000_1401, d & 32'h0000_ff01)
    wr(8'h88, 32'h0000_0101, 4'h3);
    rd(8'h88, d);
    `CHK("status_clr", 32'h0000_0000, d & 32'h0000_ff01)
    // absolute view of the table
    rd(8'h8c, d);
    `CHK("base", 32'h0000_1090, d)
    rd(8'h80, d);
    `CHK("probe_rst", 32'h0000_1090, d)
    rd(8'h90, d);
    `CHK("ctrl_rst", 32'h0000_0001, d)
    wr(8'h80, 32'h0000_1098, 4'h3);
    for (int i = 0; i < 20; i++) begin
      rd(8'h84, d);
      `CHK("probe", {24'h00_0000, EXP[i]}, d)
    end
    rd(8'h80, d);
    `CHK("probe_adv", 32'h0000_10ac, d)
    rd(8'h84, d);
    `CHK("probe_past_end", 32'h0000_00ff, d)
    rd(8'h88, d);
    `CHK("probe_miss_set", 1'b1, d[1])
    // auto-increment off: repeated reads of one byte agree
    wr(8'h90, 32'h0000_0000, 4'h1);
    wr(8'h80, 32'h0000_10a0, 4'h3);
    rd(8'h84, d);
    rd(8'h84, d2);
    `CHK("probe_hold", 32'h0000_00fe, d)
    `CHK("probe_repeat", d, d2)
    rd(8'h80, d);
    `CHK("probe_still", 32'h0000_10a0, d)
    rd(8'h88, d);
    `CHK("probe_miss_clr", 1'b0, d[1])
    rd(8'h90, d);
    `CHK("ctrl_off", 32'h0000_0000, d)
    // low lane only: upper address byte kept
    wr(8'h80, 32'h0000_0099, 4'h1);
    rd(8'h84, d);
    `CHK("probe_lane0", 32'h0000_00eb, d)
    rd(8'h80, d);
    `CHK("probe_lane0_addr", 32'h0000_1099, d)
    // unmapped places read zero and ignore writes
    wr(8'hfc, 32'hffff_ffff, 4'hf);
    rd(8'hfc, d);
    `CHK("unmapped_hi", 32'h0000_0000, d)
    rd(8'h00, d);
    `CHK("unmapped_lo", 32'h0000_0000, d)
    // counter saturates at all ones; each clear acts on its own lane
    for (int i = 0; i < 260; i++) begin
      wr(8'h6c, 32'h0000_0000, 4'hf);
    end
    rd(8'h88, d);
    `CHK("cnt_sat", 32'h0000_ff01, d & 32'h0000_ff01)
    rd(8'h6c, d);
    `CHK("table_after_many", 32'h0000_00eb, d)
    wr(8'h88, 32'h0000_0001, 4'h1);
    rd(8'h88, d);
    `CHK("seen_only_clr", 32'h0000_ff00, d & 32'h0000_ff01)
    wr(8'h88, 32'h0000_0100, 4'h2);
    rd(8'h88, d);
    `CHK("cnt_only_clr", 32'h0000_0000, d & 32'h0000_ff01)
    // mid-run reset restores the register view, table untouched
    wr(8'h20, 32'h0000_0000, 4'hf);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h80, d);
    `CHK("probe_rst2", 32'h0000_1090, d)
    rd(8'h90, d);
    `CHK("ctrl_rst2", 32'h0000_0001, d)
    rd(8'h88, d);
    `CHK("status_rst2", 32'h0000_0002, d)
    rd(8'h20, d);
    `CHK("table_rst2", 32'h0000_0048, d)
    end_sim();
  end
endmodule : tb_top
